/* File: include/feiu_pkg.sv */
// Constants for the flash event interrupt unit
package feiu_pkg;
    localparam int          REG_W        = 16;
    localparam int          ADDR_W       = 8;
    // ***************************************************************
    // Register offsets (byte addresses)
    // ***************************************************************
    localparam logic [7:0]  CFG_OFFSET   = 8'h00;
    localparam logic [7:0]  STAT_OFFSET  = 8'h04;
    // ***************************************************************
    // Field positions
    // ***************************************************************
    localparam int          OUT_DIS_BIT  = 15;
    localparam int          READY_BIT    = 4;
    localparam int          POR_BIT      = 2;
    localparam int          ECC2_BIT     = 1;
    localparam int          ECC1_BIT     = 0;
    // ***************************************************************
    // Reset values and masks
    // ***************************************************************
    localparam logic [15:0] CFG_RESET    = 16'hffff;
    localparam logic [15:0] STAT_POR     = 16'hfffb;
    localparam logic [15:0] STAT_HW      = 16'hffff;
    localparam logic [15:0] EVENT_MASK   = 16'h0013;
    localparam logic [15:0] CFG_WR_MASK  = 16'h8013;
    localparam logic [15:0] STAT_WR_MASK = 16'h0017;
endpackage

/* File: verif/feiu_host_model.sv */
// Host side of the interrupt pin: pull-up resistor and input buffer
module feiu_host_model (
    input  wire logic int_n_i,
    input  wire logic int_n_oe_i,
    output logic      pin_o
);
    timeunit 1ns;
    timeprecision 100ps;
    // Released pin floats up through the external resistor
    assign pin_o = int_n_oe_i ? int_n_i : 1'b1;
endmodule

/* File: verif/feiu_top_tb.sv */
// Self-checking bench for the flash event interrupt unit
module feiu_top_tb;
    import feiu_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic        ref_clk_i, rst_i, hw_rst_n_i, psel_i, penable_i, pwrite_i;
    logic [2:0]  evt;
    logic [7:0]  paddr_i;
    logic [31:0] pwdata_i, prdata_o, rd;
    logic        pready_o, pslverr_o, int_n_o, int_n_oe_o, int_pending_o;
    logic        pin, err;
    int          bad_count = 0;
    int          n_tests = 0;
    int          cyc = 0;

    feiu_top i_feiu_top (
        .ref_clk_i(ref_clk_i), .rst_i(rst_i), .hw_rst_n_i(hw_rst_n_i),
        .evt_ready_i(evt[2]), .evt_ecc2_i(evt[1]), .evt_ecc1_i(evt[0]),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
        .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
        .pslverr_o(pslverr_o), .prdata_o(prdata_o), .int_n_o(int_n_o),
        .int_n_oe_o(int_n_oe_o), .int_pending_o(int_pending_o));
    feiu_host_model i_feiu_host_model (
        .int_n_i(int_n_o), .int_n_oe_i(int_n_oe_o), .pin_o(pin));

    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end

    // Whole run needs about 200 cycles
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            test_done();
        end
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic pinc(input logic exp);
        chk({31'h0, pin}, {31'h0, exp});
    endtask

    // Events in ev land on the completion edge, one wait state after take
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic [2:0] ev);
        int n;
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk_i);
            evt <= (n == 0) ? ev : 3'h0;
            n++;
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 3'h0);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 3'h0);
        chk(rd, exp);
    endtask

    task automatic pulse(input logic [2:0] ev);
        evt <= ev;
        @(posedge ref_clk_i);
        evt <= 3'h0;
        @(posedge ref_clk_i);
    endtask

    task automatic t_reset();
        rdc(CFG_OFFSET, 32'h0000ffff);
        rdc(STAT_OFFSET, 32'h0000fffb);
        pinc(1'b1);
        wr(CFG_OFFSET, 32'h0);
        pinc(1'b1);
        rdc(CFG_OFFSET, 32'h00007fec);
        wr(STAT_OFFSET, 32'h0);
        rdc(STAT_OFFSET, 32'h0000fffb);
        wr(STAT_OFFSET, 32'h4);
        rdc(STAT_OFFSET, 32'h0000ffff);
    endtask

    task automatic t_each_event();
        logic [31:0] m;
        for (int i = 0; i < 3; i++) begin
            m = (i == 2) ? 32'h10 : (32'h1 << i);
            pulse(3'h1 << i);
            pinc(1'b0);
            chk({30'h0, int_n_oe_o, int_n_o}, 32'h2);
            rdc(STAT_OFFSET, 32'h0000ffff & ~m);
            wr(STAT_OFFSET, m);
            rdc(STAT_OFFSET, 32'h0000ffff);
            pinc(1'b1);
        end
    endtask

    task automatic t_two_flags();
        pulse(3'b101);
        wr(STAT_OFFSET, 32'h10);
        rdc(STAT_OFFSET, 32'h0000fffe);
        pinc(1'b0);
        wr(STAT_OFFSET, 32'h1f);
        pinc(1'b1);
    endtask

    task automatic t_enables();
        wr(CFG_OFFSET, 32'h1);
        pulse(3'b001);
        rdc(STAT_OFFSET, 32'h0000ffff);
        pinc(1'b1);
        pulse(3'b010);
        pinc(1'b0);
        wr(CFG_OFFSET, 32'h2);
        rdc(STAT_OFFSET, 32'h0000ffff);
        pinc(1'b1);
    endtask

    task automatic t_out_disable();
        wr(CFG_OFFSET, 32'h0);
        pulse(3'b011);
        wr(CFG_OFFSET, 32'h8000);
        rdc(STAT_OFFSET, 32'h0000ffff);
        pinc(1'b1);
        pulse(3'b001);
        rdc(STAT_OFFSET, 32'h0000fffe);
        pinc(1'b1);
        chk({31'h0, int_pending_o}, 32'h1);
        wr(CFG_OFFSET, 32'h0);
        pinc(1'b0);
    endtask

    task automatic t_race();
        apb(1'b1, STAT_OFFSET, 32'h1, 3'b001);
        rdc(STAT_OFFSET, 32'h0000fffe);
        wr(STAT_OFFSET, 32'h1);
        rdc(STAT_OFFSET, 32'h0000ffff);
    endtask

    task automatic t_unmapped();
        apb(1'b0, 8'h08, 32'h0, 3'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        wr(8'h08, 32'hffff);
        rdc(CFG_OFFSET, 32'h00007fec);
        chk({31'h0, err}, 32'h0);
    endtask

    task automatic t_resets();
        pulse(3'b001);
        hw_rst_n_i <= 1'b0;
        @(posedge ref_clk_i);
        hw_rst_n_i <= 1'b1;
        @(posedge ref_clk_i);
        pinc(1'b1);
        rdc(CFG_OFFSET, 32'h0000ffff);
        rdc(STAT_OFFSET, 32'h0000ffff);
        rst_i <= 1'b1;
        repeat (3) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        rdc(STAT_OFFSET, 32'h0000fffb);
        wr(CFG_OFFSET, 32'h8000);
        rdc(STAT_OFFSET, 32'h0000fffb);
    endtask

    initial begin
        rst_i = 1'b1;
        hw_rst_n_i = 1'b1;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 8'h00;
        pwdata_i = 32'h0;
        evt = 3'h0;
        repeat (10) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        @(posedge ref_clk_i);
        t_reset();
        t_each_event();
        t_two_flags();
        t_enables();
        t_out_disable();
        t_race();
        t_unmapped();
        t_resets();
        test_done();
    end
endmodule

/* File: verilog/feiu_apb_slave.sv */
// APB slave front end with one wait state and registered answers
module feiu_apb_slave
    import feiu_pkg::*;
(
    input  wire logic                      ref_clk_i,
    input  wire logic                      rst_i,
    input  wire logic                      psel_i,
    input  wire logic                      penable_i,
    input  wire logic                      pwrite_i,
    input  wire logic [feiu_pkg::ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]               pwdata_i,
    input  wire logic [15:0]               cfg_i,
    input  wire logic [15:0]               stat_i,
    output logic                           pready_o,
    output logic                           pslverr_o,
    output logic [31:0]                    prdata_o,
    output logic                           wr_cfg_o,
    output logic                           wr_stat_o
);
    import feiu_pkg::*;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } feiu_apb_type;

    feiu_apb_type s_r;
    feiu_apb_type s_nxt;
    logic         hit_cfg;
    logic         hit_stat;
    logic         commit;

    assign hit_cfg  = (paddr_i == CFG_OFFSET);
    assign hit_stat = (paddr_i == STAT_OFFSET);
    // Writes land only on the edge that completes the transfer
    assign commit    = psel_i & penable_i & s_r.pready;
    assign wr_cfg_o  = commit & pwrite_i & hit_cfg;
    assign wr_stat_o = commit & pwrite_i & hit_stat;

    always_comb begin
        s_nxt        = s_r;
        s_nxt.pready = 1'b0;
        if (psel_i && penable_i && !s_r.pready) begin
            s_nxt.pready  = 1'b1;
            s_nxt.pslverr = !(hit_cfg || hit_stat);
            s_nxt.prdata  = 32'h0000_0000;
            if (!pwrite_i && hit_cfg) begin
                s_nxt.prdata = {16'h0000, cfg_i};
            end else if (!pwrite_i && hit_stat) begin
                s_nxt.prdata = {16'h0000, stat_i};
            end
        end else if (commit) begin
            s_nxt.pslverr = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign pready_o  = s_r.pready;
    assign pslverr_o = s_r.pslverr;
    assign prdata_o  = s_r.prdata;
endmodule

/* File: verilog/feiu_top.sv */
// Event flags, enables and open-drain interrupt pin of the flash
module feiu_top
    import feiu_pkg::*;
(
    input  wire logic                        ref_clk_i,
    input  wire logic                        rst_i,
    input  wire logic                        hw_rst_n_i,
    input  wire logic                        evt_ready_i,
    input  wire logic                        evt_ecc2_i,
    input  wire logic                        evt_ecc1_i,
    input  wire logic                        psel_i,
    input  wire logic                        penable_i,
    input  wire logic                        pwrite_i,
    input  wire logic [feiu_pkg::ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]                 pwdata_i,
    output logic                             pready_o,
    output logic                             pslverr_o,
    output logic [31:0]                      prdata_o,
    output logic                             int_n_o,
    output logic                             int_n_oe_o,
    output logic                             int_pending_o
);
    import feiu_pkg::*;

    // ***************************************************************
    // State
    // ***************************************************************
    typedef struct packed {
        logic [15:0] cfg;
        logic [15:0] stat;
        logic        drive_lvl;
        logic        int_oe;
        logic        pending;
    } feiu_state_type;

    feiu_state_type s_r;
    feiu_state_type s_nxt;
    logic           wr_cfg;
    logic           wr_stat;
    logic [15:0]    wdata;
    logic [15:0]    evt_vec;
    logic [15:0]    evt_en;
    logic [15:0]    clr_vec;
    logic [15:0]    stat_w1s;

    // Pin pulls low when output enabled and an enabled flag is occurred.
    // Bit 2 is outside the event mask, so it can never reach the pin.
    function automatic logic pin_pull(input logic [15:0] cfg,
                                      input logic [15:0] stat);
        logic [15:0] act;
        act      = ~stat & ~cfg & EVENT_MASK;
        pin_pull = !cfg[OUT_DIS_BIT] && (|act);
    endfunction

    // ***************************************************************
    // Register bus
    // ***************************************************************
    feiu_apb_slave u_apb (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .psel_i    (psel_i),
        .penable_i (penable_i),
        .pwrite_i  (pwrite_i),
        .paddr_i   (paddr_i),
        .pwdata_i  (pwdata_i),
        .cfg_i     (s_r.cfg),
        .stat_i    (s_r.stat),
        .pready_o  (pready_o),
        .pslverr_o (pslverr_o),
        .prdata_o  (prdata_o),
        .wr_cfg_o  (wr_cfg),
        .wr_stat_o (wr_stat)
    );

    assign wdata = pwdata_i[15:0];

    // ***************************************************************
    // Event capture
    // ***************************************************************
    always_comb begin
        evt_vec            = 16'h0000;
        evt_vec[READY_BIT] = evt_ready_i;
        evt_vec[ECC2_BIT]  = evt_ecc2_i;
        evt_vec[ECC1_BIT]  = evt_ecc1_i;
    end

    // Enables sampled before any same-cycle config write
    assign evt_en   = evt_vec & ~s_r.cfg & EVENT_MASK;
    assign stat_w1s = s_r.stat | (wdata & STAT_WR_MASK);

    // ***************************************************************
    // Next state
    // ***************************************************************
    always_comb begin
        s_nxt           = s_r;
        clr_vec         = 16'h0000;
        s_nxt.drive_lvl = 1'b0;
        if (wr_cfg) begin
            // Reserved config bits stay at one
            s_nxt.cfg = (wdata & CFG_WR_MASK) | ~CFG_WR_MASK;
            if (wdata[OUT_DIS_BIT]) begin
                // Power-on flag kept; only a status write or a hardware reset sets it
                clr_vec = STAT_POR;
            end else begin
                clr_vec = wdata & EVENT_MASK;
            end
        end
        if (wr_stat) begin
            clr_vec = clr_vec | (wdata & STAT_WR_MASK);
        end
        // Event wins over a clear in the same cycle
        s_nxt.stat = (s_r.stat | clr_vec) & ~evt_en;
        if (!hw_rst_n_i) begin
            s_nxt.cfg  = CFG_RESET;
            s_nxt.stat = STAT_HW;
        end
        s_nxt.int_oe  = pin_pull(s_nxt.cfg, s_nxt.stat);
        s_nxt.pending = |(~s_nxt.stat & ~s_nxt.cfg & EVENT_MASK);
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_r.cfg       <= CFG_RESET;
            s_r.stat      <= STAT_POR;
            s_r.drive_lvl <= 1'b0;
            s_r.int_oe    <= 1'b0;
            s_r.pending   <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Level is always low; the enable alone makes it open-drain
    assign int_n_o       = s_r.drive_lvl;
    assign int_n_oe_o    = s_r.int_oe;
    assign int_pending_o = s_r.pending;

    // ***************************************************************
    // Assertions
    // ***************************************************************
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_ready_hit;
        evt_ready_i && !s_r.cfg[READY_BIT] && hw_rst_n_i;
    endsequence

    sequence s_out_on;
        !s_r.cfg[OUT_DIS_BIT] && !wr_cfg;
    endsequence

    property p_pin_low_level;
        int_n_o == 1'b0;
    endproperty
    a_pin_low_level: assert property (p_pin_low_level)
        else $error("interrupt pin level not low");

    property p_out_disabled;
        s_r.cfg[OUT_DIS_BIT] |-> !int_n_oe_o;
    endproperty
    a_out_disabled: assert property (p_out_disabled)
        else $error("pin driven while output disabled");

    property p_global_clear;
        wr_cfg && wdata[OUT_DIS_BIT] && (evt_en == 16'h0000)
            && hw_rst_n_i
        |=> s_r.stat == (STAT_POR | $past(s_r.stat)) && !int_n_oe_o;
    endproperty
    a_global_clear: assert property (p_global_clear)
        else $error("status not cleared by output disable");

    property p_enable_gates;
        evt_ecc2_i && s_r.cfg[ECC2_BIT] && s_r.stat[ECC2_BIT]
            && hw_rst_n_i
        |=> s_r.stat[ECC2_BIT];
    endproperty
    a_enable_gates: assert property (p_enable_gates)
        else $error("disabled event latched");

    property p_channel_clear;
        wr_cfg && wdata[READY_BIT] && !evt_ready_i && hw_rst_n_i
        |=> s_r.stat[READY_BIT];
    endproperty
    a_channel_clear: assert property (p_channel_clear)
        else $error("channel disable left flag set");

    property p_ecc1_flag;
        evt_ecc1_i && !s_r.cfg[ECC1_BIT] && hw_rst_n_i
        |=> !s_r.stat[ECC1_BIT];
    endproperty
    a_ecc1_flag: assert property (p_ecc1_flag)
        else $error("1-bit error event not recorded");

    property p_flag_holds;
        !s_r.stat[ECC2_BIT] && !wr_cfg && !wr_stat && hw_rst_n_i
        |=> !s_r.stat[ECC2_BIT];
    endproperty
    a_flag_holds: assert property (p_flag_holds)
        else $error("flag dropped without a clear");

    property p_pin_falls;
        s_ready_hit ##0 s_out_on ##0 !int_n_oe_o |=> $rose(int_n_oe_o);
    endproperty
    a_pin_falls: assert property (p_pin_falls)
        else $error("pin did not fall on enabled event");

    property p_event_pulls;
        s_ready_hit ##0 s_out_on |=> int_n_oe_o;
    endproperty
    a_event_pulls: assert property (p_event_pulls)
        else $error("enabled event did not pull pin");

    property p_pin_holds;
        int_n_oe_o && !wr_cfg && !wr_stat && hw_rst_n_i
        |=> int_n_oe_o;
    endproperty
    a_pin_holds: assert property (p_pin_holds)
        else $error("pin released with flags pending");

    property p_w1s_only;
        wr_stat && (evt_en == 16'h0000) && !wr_cfg && hw_rst_n_i
        |=> s_r.stat == $past(stat_w1s);
    endproperty
    a_w1s_only: assert property (p_w1s_only)
        else $error("status write did more than set bits");

    property p_no_soft_set;
        (evt_en == 16'h0000) && hw_rst_n_i
        |=> (s_r.stat & $past(s_r.stat)) == $past(s_r.stat);
    endproperty
    a_no_soft_set: assert property (p_no_soft_set)
        else $error("flag occurred without an event");

    property p_hw_reset_cfg;
        !hw_rst_n_i |=> s_r.cfg == CFG_RESET && !int_n_oe_o;
    endproperty
    a_hw_reset_cfg: assert property (p_hw_reset_cfg)
        else $error("hardware reset left config or pin");

    property p_hw_reset_stat;
        !hw_rst_n_i |=> s_r.stat == STAT_HW;
    endproperty
    a_hw_reset_stat: assert property (p_hw_reset_stat)
        else $error("hardware reset left status bits low");

    property p_por_value;
        $fell(rst_i) |-> s_r.stat == STAT_POR && s_r.cfg == CFG_RESET;
    endproperty
    a_por_value: assert property (p_por_value)
        else $error("power-on values wrong");

    property p_por_flag_sticky;
        !s_r.stat[POR_BIT] && !wr_stat && hw_rst_n_i
        |=> !s_r.stat[POR_BIT];
    endproperty
    a_por_flag_sticky: assert property (p_por_flag_sticky)
        else $error("power-on flag set without cause");

    property p_por_ignored;
        int_n_oe_o == pin_pull(s_r.cfg, s_r.stat | 16'h0004);
    endproperty
    a_por_ignored: assert property (p_por_ignored)
        else $error("pin follows power-on flag");

    property p_event_wins;
        s_ready_hit ##0 (wr_stat && wdata[READY_BIT])
        |=> !s_r.stat[READY_BIT];
    endproperty
    a_event_wins: assert property (p_event_wins)
        else $error("clear beat a same-cycle event");

    property p_release_on_clear;
        int_n_oe_o && wr_stat && (wdata[4:0] == 5'h1f)
            && (evt_en == 16'h0000)
        |=> !int_n_oe_o;
    endproperty
    a_release_on_clear: assert property (p_release_on_clear)
        else $error("pin held after all flags cleared");

    property p_apb_wait;
        psel_i && penable_i && !pready_o |=> pready_o ##1 !pready_o;
    endproperty
    a_apb_wait: assert property (p_apb_wait)
        else $error("bus answer not one wait state");
endmodule
